// >>> dv/iacs_dev_model.sv
// iacs_dev_model: behavioural converter slave on the two-wire bus
// assumes: pulled-up wires resolved outside, sampled on clk
module iacs_dev_model (
  // clock, reset, select pins
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [1:0] sel_pins,
  // resolved wires
  input  wire logic       scl,
  input  wire logic       sda,
  // line drive, high pulls low
  output logic            scl_oe,
  output logic            sda_oe,
  // observation
  output logic [7:0]      cmd,
  output logic            ref_on,
  output logic [7:0]      n_start,
  output logic [7:0]      n_stop,
  output logic [7:0]      n_rd
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] sel;
  logic [1:0] st;  // 0 idle, 1 address, 2 command, 3 reading
  logic [7:0] sh;
  logic [3:0] bc;
  logic [3:0] nb;
  logic [7:0] tx;
  logic       ps;
  logic       pd;
  logic       e7;
  logic       mine;
  logic [5:0] hold;
  assign nb   = (bc == 4'h8) ? 4'h0 : bc + 4'h1;
  assign e7   = (bc == 4'h7);
  assign tx   = {cmd[7:4], n_rd[3:0]};
  assign mine = (sh[7:3] == iacs_pkg::ADDR_PREFIX) && (sh[2:1] == sel);
  ////////////////////////////////////////
  always_ff @(posedge clk) begin
    ps <= scl;
    pd <= sda;
    if (rst) begin
      sel     <= sel_pins;
      st      <= 2'h0;
      sda_oe  <= 1'b0;
      cmd     <= 8'h00;
      ref_on  <= 1'b0;
      n_start <= 8'h00;
      n_stop  <= 8'h00;
      n_rd    <= 8'h00;
    end else if (ps && scl && pd && !sda) begin
      st      <= 2'h1;
      bc      <= 4'hF;  // fall after start wraps to 0
      sda_oe  <= 1'b0;
      n_rd    <= 8'h00;
      n_start <= n_start + 8'h01;
      ref_on  <= cmd[3];
    end else if (ps && scl && !pd && sda) begin
      st     <= 2'h0;
      sda_oe <= 1'b0;
      n_stop <= n_stop + 8'h01;
      ref_on <= cmd[3];
    end else if (!ps && scl && st != 2'h0) begin
      if (bc != 4'h8)
        sh <= {sh[6:0], sda};
      else if (st == 2'h3 && sda)
        st <= 2'h0;
    end else if (ps && !scl && st != 2'h0) begin
      bc     <= nb;
      sda_oe <= 1'b0;
      if (e7 && st == 2'h1 && !mine)
        st <= 2'h0;
      if (e7 && (st == 2'h2 || (st == 2'h1 && mine)))
        sda_oe <= 1'b1;
      if (e7 && st == 2'h2)
        cmd <= sh;
      if (e7 && st == 2'h3)
        n_rd <= n_rd + 8'h01;
      if (bc == 4'h8 && st == 2'h1)
        st <= sh[0] ? 2'h3 : 2'h2;
      if ((st == 2'h3 || (st == 2'h1 && sh[0] && bc == 4'h8)) && nb != 4'h8)
        sda_oe <= !tx[3'h7 - nb[2:0]];
    end
  end
  // hold clock low after the read address byte
  always_ff @(posedge clk) begin
    if (rst)
      hold <= 6'h00;
    else if (ps && !scl && st == 2'h1 && e7 && mine && sh[0])
      hold <= 6'h28;
    else if (hold != 6'h00)
      hold <= hold - 6'h01;
  end
  assign scl_oe = (hold != 6'h00);
endmodule // iacs_dev_model

// >>> dv/test_iacs_host.sv
// test_iacs_host: self-checking bench for the two-wire converter host
// assumes: slave model on pulled-up wires, avalon master driven here
module test_iacs_host;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] QTR = 32'h0000_0008;
  logic        clk_sys, srst, avs_read, avs_write, avs_waitrequest;
  logic [3:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic        scl_oe, sda_oe, m_oe, m_scl, scl, sda, m_ref;
  logic [7:0]  m_cmd, m_ns, m_np, m_nr;
  int          fails, n_checks;
  assign scl = !(scl_oe | m_scl);
  assign sda = !(sda_oe | m_oe);
  iacs_host i_iacs_host (.CLK_SYS(clk_sys), .SRST(srst), .AVS_ADDRESS(avs_address), .AVS_READ(avs_read),
    .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata), .AVS_READDATA(avs_readdata),
    .AVS_WAITREQUEST(avs_waitrequest), .SCL_IN(scl), .SCL_OUT(), .SCL_OE(scl_oe), .SDA_IN(sda),
    .SDA_OUT(), .SDA_OE(sda_oe));
  iacs_dev_model i_iacs_dev_model (.clk(clk_sys), .rst(srst), .sel_pins(2'h2), .scl(scl), .sda(sda),
    .scl_oe(m_scl), .sda_oe(m_oe), .cmd(m_cmd), .ref_on(m_ref), .n_start(m_ns), .n_stop(m_np), .n_rd(m_nr));
  ////////////////////////////////////////
  task test_done;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task av(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_sys);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 50);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    if (k >= 50) begin
      fails++;
      test_done;
    end
  endtask
  task wait_done;
    int k;
    k = 0;
    do begin
      av(1'b0, iacs_pkg::ADDR_STATUS, 32'h0000_0000);
      k++;
    end while (rd[iacs_pkg::STAT_DONE_BIT] !== 1'b1 && k < 3000);
    if (k >= 3000) begin
      fails++;
      test_done;
    end
  endtask
  task go(input logic [7:0] c, input logic [7:0] n);
    av(1'b1, iacs_pkg::ADDR_CTRL, {8'h00, n, 8'h01, c});
  endtask
  ////////////////////////////////////////
  task t_regs;
    av(1'b0, iacs_pkg::ADDR_DIVIDER, 32'h0000_0000);
    chk(rd, iacs_pkg::RESET_DIVIDER);
    av(1'b0, iacs_pkg::ADDR_STATUS, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    chk(m_ns, 8'h00);
    av(1'b1, 4'hF, 32'hFFFF_FFFF);
    av(1'b0, 4'hF, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    av(1'b1, iacs_pkg::ADDR_DIVIDER, QTR);
    av(1'b0, iacs_pkg::ADDR_DIVIDER, 32'h0000_0000);
    chk(rd, QTR);
    av(1'b1, iacs_pkg::ADDR_SELECT, 32'h0000_0002);
    $display("regs test finished");
  endtask
  task t_modes;
    logic [7:0] c, n, nn, s0, p0;
    for (int i = 0; i < 8; i++) begin
      c  = {i[0], i[2:0], i[2:1], 2'h3};
      n  = {6'h00, i[1:0]};
      nn = (n == 8'h00) ? 8'h01 : n;
      s0 = m_ns;
      p0 = m_np;
      go(c, n);
      wait_done;
      chk(rd[2:0], 3'h4);
      chk(m_cmd, c);
      chk(m_nr, nn);
      chk(m_ns - s0, 8'h02);
      chk(m_np - p0, 8'h01);
      chk(m_ref, c[3]);
      av(1'b0, iacs_pkg::ADDR_RESULT, 32'h0000_0000);
      chk(rd[7:0], {c[7:4], 4'h0} + nn - 8'h01);
    end
    $display("modes test finished");
  endtask
  task t_nack;
    logic [7:0] c0, p0;
    c0 = m_cmd;
    p0 = m_np;
    av(1'b1, iacs_pkg::ADDR_SELECT, 32'h0000_0001);
    go(8'h8C, 8'h01);
    wait_done;
    chk(rd[2:0], 3'h6);
    chk(m_cmd, c0);
    chk(m_np - p0, 8'h01);
    av(1'b1, iacs_pkg::ADDR_SELECT, 32'h0000_0002);
    $display("nack test finished");
  endtask
  task t_busy;
    logic [7:0] s0;
    s0 = m_ns;
    go(8'hF4, 8'h02);
    go(8'h04, 8'h01);
    wait_done;
    chk(m_cmd, 8'h04);
    chk(m_nr, 8'h02);
    chk(m_ns - s0, 8'h02);
    $display("busy test finished");
  endtask
  ////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    srst          = 1'b1;
    avs_read      = 1'b0;
    avs_write     = 1'b0;
    avs_address   = 4'h0;
    avs_writedata = 32'h0000_0000;
    fails         = 0;
    n_checks      = 0;
    repeat (5) @(posedge clk_sys);
    srst <= 1'b0;
    t_regs;
    t_modes;
    t_nack;
    t_busy;
    test_done;
  end
endmodule // test_iacs_host

// >>> inc/iacs_pkg.sv
// iacs_pkg: shared constants and types for the two-wire converter host
// assumes: 100 MHz system clock, synchronous active-high reset
package iacs_pkg;

  // register map, word addresses on the avalon slave
  localparam logic [3:0] ADDR_CTRL    = 4'h0;
  localparam logic [3:0] ADDR_STATUS  = 4'h1;
  localparam logic [3:0] ADDR_RESULT  = 4'h2;
  localparam logic [3:0] ADDR_DIVIDER = 4'h3;
  localparam logic [3:0] ADDR_SELECT  = 4'h4;

  // control register fields
  localparam int CTRL_CMD_LSB   = 0;   // command byte bits 7:0
  localparam int CTRL_GO_BIT    = 8;   // write 1 while not busy: run one command/read sequence
  localparam int CTRL_COUNT_LSB = 16;  // bytes to read, bits 23:16
  localparam int CTRL_COUNT_W   = 8;

  // status register fields
  localparam int STAT_BUSY_BIT  = 0;
  localparam int STAT_NACK_BIT  = 1;
  localparam int STAT_DONE_BIT  = 2;

  // command byte fields
  localparam int CMD_MODE_BIT   = 7;
  localparam int CMD_CH_MSB     = 6;
  localparam int CMD_CH_LSB     = 4;
  localparam int CMD_REF_BIT    = 3;
  localparam int CMD_CONV_BIT   = 2;

  // address byte: fixed prefix, two select bits, direction
  localparam logic [4:0] ADDR_PREFIX = 5'h0B;  // arbitrary value
  localparam logic       DIR_READ    = 1'b1;
  localparam logic       DIR_WRITE   = 1'b0;

  // timing: standard-mode bus clock, 100 kHz from 100 MHz
  localparam int SYS_CLK_HZ      = 100_000_000;
  localparam int BUS_CLK_HZ      = 100_000;
  localparam int QUARTER_CYCLES  = SYS_CLK_HZ / (BUS_CLK_HZ * 4);

  localparam logic [31:0] RESET_DIVIDER = 32'h0000_00FA;

  // one bus phase request to the bit engine
  typedef enum logic [5:0] {
    OP_IDLE    = 6'b00_0001,
    OP_START   = 6'b00_0010,
    OP_STOP    = 6'b00_0100,
    OP_WBIT    = 6'b00_1000,
    OP_RBIT    = 6'b01_0000,
    OP_RSTART  = 6'b10_0000
  } iacs_op_type;

  typedef struct packed {
    iacs_op_type op;
    logic        wbit;
  } iacs_req_type;

  typedef struct packed {
    logic done;
    logic rbit;
  } iacs_rsp_type;

endpackage : iacs_pkg

// >>> logic/iacs_bit_engine.sv
// iacs_bit_engine: drives one start, stop or bit on the two wires
// assumes: pins already synchronised by the caller; open-drain outputs
module iacs_bit_engine (
  // clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  srst,
  // quarter-period length in system cycles
  input  wire logic [15:0]           quarter,
  // request and answer
  input  wire iacs_pkg::iacs_req_type req,
  output iacs_pkg::iacs_rsp_type     rsp,
  // synchronised line levels
  input  wire logic                  scl_in,
  input  wire logic                  sda_in,
  // open-drain drive: enable high pulls low
  output logic                       scl_oe,
  output logic                       sda_oe
);

  logic [15:0] count;
  logic [1:0]  phase;
  logic        active;
  logic        sample;
  iacs_pkg::iacs_op_type op;
  logic        wbit;

  wire quarter_done = (count == 16'h0000);
  // a clock held low by the far end stretches the high phase
  wire stretched    = (phase == 2'd2) && !scl_in;
  wire last_phase   = (phase == 2'd3) && quarter_done;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      active <= 1'b0;
      count  <= 16'h0000;
      phase  <= 2'd0;
      op     <= iacs_pkg::OP_IDLE;
      wbit   <= 1'b1;
      sample <= 1'b1;
      rsp    <= '0;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      rsp.done <= 1'b0;
      if (!active) begin
        if (req.op != iacs_pkg::OP_IDLE) begin
          active <= 1'b1;
          op     <= req.op;
          wbit   <= req.wbit;
          phase  <= 2'd0;
          count  <= quarter;
        end
      end else if (!quarter_done) begin
        count <= count - 16'h0001;
      end else if (!stretched) begin
        count <= quarter;
        phase <= phase + 2'd1;
        if (last_phase) begin
          active   <= 1'b0;
          rsp.done <= 1'b1;
          rsp.rbit <= sample;
        end
      end
      if (active && quarter_done && !stretched) begin
        case (op)
          // R2: data falls while clock high; R10: same after raising both
          iacs_pkg::OP_START, iacs_pkg::OP_RSTART: begin
            case (phase)
              2'd0:    begin scl_oe <= 1'b0; sda_oe <= 1'b0; end
              2'd1:    begin scl_oe <= 1'b0; sda_oe <= 1'b1; end
              2'd2:    begin scl_oe <= 1'b1; sda_oe <= 1'b1; end
              default: begin scl_oe <= 1'b1; sda_oe <= 1'b1; end
            endcase
          end
          // R3: data rises while clock high
          iacs_pkg::OP_STOP: begin
            case (phase)
              2'd0:    begin scl_oe <= 1'b1; sda_oe <= 1'b1; end
              2'd1:    begin scl_oe <= 1'b0; sda_oe <= 1'b1; end
              2'd2:    begin scl_oe <= 1'b0; sda_oe <= 1'b0; end
              default: begin scl_oe <= 1'b0; sda_oe <= 1'b0; end
            endcase
          end
          // R4: data set only while clock low, held through the high phase
          iacs_pkg::OP_WBIT, iacs_pkg::OP_RBIT: begin
            case (phase)
              2'd0:    begin scl_oe <= 1'b1; sda_oe <= (op == iacs_pkg::OP_WBIT) && !wbit; end
              2'd1:    scl_oe <= 1'b0;
              2'd2:    sample <= sda_in;
              default: scl_oe <= 1'b1;
            endcase
          end
          default: begin
            scl_oe <= scl_oe;
            sda_oe <= sda_oe;
          end
        endcase
      end
    end
  end

endmodule // iacs_bit_engine

// >>> logic/iacs_host.sv
// iacs_host: two-wire bus master driving an 8-channel converter slave
// assumes: open-drain wires resolved outside; avalon master on CLK_SYS
//
// What the bus, this block and the slave must do
// [R1] host alone makes clock, start and stop
// [R2] start: data falls while clock high
// [R3] stop: data rises while clock high
// [R4] data changes only while clock low
// [R5] start only when bus idle, both high
// [R6] eight bits per byte plus acknowledge
// [R7] extra clock for acknowledge; low means ack
// [R8] host nacks last read byte, then stops
// [R9] host chooses how many bytes to read
// [R10] repeated start begins new addressed transfer
// [R11] address: fixed prefix, select bits, direction
// [R12] select bits fixed by slave at power-up
// [R13] direction one reads, zero writes
// [R14] slave acks only a matching address
// [R15] slave acks each received byte
// [R16] slave shifts data out on host clock
// [R17] command byte: mode, channel, two power bits
// [R18] mode bit zero differential, one single-ended
// [R19] power bits choose four power states
// [R20] bus clock up to 100k/400k/3.4M
// [R21] command byte starts a conversion
// [R22] read returns one byte, msb first
// [R23] slave may hold clock low while converting
// [R24] reference turns on after stop or restart
// [R25] slave keeps last command for later conversions
module iacs_host #(
  parameter int SETTLE_CYCLES = 4
) (
  // system
  input  wire logic        CLK_SYS,
  input  wire logic        SRST,
  // avalon-mm slave
  input  wire logic [3:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0]      AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  // two-wire bus, open drain
  input  wire logic        SCL_IN,
  output logic             SCL_OUT,
  output logic             SCL_OE,
  input  wire logic        SDA_IN,
  output logic             SDA_OUT,
  output logic             SDA_OE
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      scl_sync <= 2'b11;
      sda_sync <= 2'b11;
    end else begin
      scl_sync <= {scl_sync[0], SCL_IN};
      sda_sync <= {sda_sync[0], SDA_IN};
    end
  end
  wire scl_s = scl_sync[1];
  wire sda_s = sda_sync[1];

  ////////////////////////////////////////////////////////////////////////////
  // registers

  logic [7:0]  cmd_byte;
  logic [1:0]  dev_select;
  logic [7:0]  read_count;
  logic [15:0] quarter;
  logic [7:0]  result;
  logic        busy;
  logic        nack_seen;
  logic        done_flag;
  logic        go_pulse;

  // R17 R18 R19: decoded command fields, for status readback
  wire       mode_single = cmd_byte[iacs_pkg::CMD_MODE_BIT];
  wire [2:0] channel     = cmd_byte[iacs_pkg::CMD_CH_MSB:iacs_pkg::CMD_CH_LSB];
  wire [1:0] power_state = {cmd_byte[iacs_pkg::CMD_REF_BIT], cmd_byte[iacs_pkg::CMD_CONV_BIT]};

  function automatic logic [7:0] addr_byte(input logic [1:0] sel, input logic dir);
    addr_byte = {iacs_pkg::ADDR_PREFIX, sel, dir};   // R11 R13
  endfunction

  wire wr_ctrl = AVS_WRITE && (AVS_ADDRESS == iacs_pkg::ADDR_CTRL);
  wire go_req  = wr_ctrl && AVS_WRITEDATA[iacs_pkg::CTRL_GO_BIT] && !busy;
  logic done_set;

  wire [31:0] rd_mux =
    (AVS_ADDRESS == iacs_pkg::ADDR_CTRL)    ? {8'h00, read_count, 8'h00, cmd_byte} :
    (AVS_ADDRESS == iacs_pkg::ADDR_STATUS)  ? {23'h00_0000, mode_single, channel, power_state,
                                               done_flag, nack_seen, busy} :
    (AVS_ADDRESS == iacs_pkg::ADDR_RESULT)  ? {24'h0000_00, result} :
    (AVS_ADDRESS == iacs_pkg::ADDR_DIVIDER) ? {16'h0000, quarter} :
    (AVS_ADDRESS == iacs_pkg::ADDR_SELECT)  ? {30'h0000_0000, dev_select} : 32'h0000_0000;

  // waitrequest low one cycle after each access: one-wait-state slave
  logic ack_phase;
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      ack_phase       <= 1'b0;
      AVS_WAITREQUEST <= 1'b1;
      AVS_READDATA    <= 32'h0000_0000;
      cmd_byte        <= 8'h00;
      dev_select      <= 2'b00;
      read_count      <= 8'h01;
      quarter         <= 16'(iacs_pkg::QUARTER_CYCLES);
      go_pulse        <= 1'b0;
      done_flag       <= 1'b0;
    end else begin
      go_pulse        <= 1'b0;
      ack_phase       <= (AVS_READ || AVS_WRITE) && !ack_phase;
      AVS_WAITREQUEST <= !((AVS_READ || AVS_WRITE) && !ack_phase);
      if (AVS_READ && !ack_phase) AVS_READDATA <= rd_mux;
      if (AVS_WRITE && ack_phase) begin
        case (AVS_ADDRESS)
          iacs_pkg::ADDR_CTRL: begin
            cmd_byte   <= AVS_WRITEDATA[iacs_pkg::CTRL_CMD_LSB +: 8];
            read_count <= AVS_WRITEDATA[iacs_pkg::CTRL_COUNT_LSB +: iacs_pkg::CTRL_COUNT_W];
            go_pulse   <= go_req;
          end
          iacs_pkg::ADDR_DIVIDER: quarter    <= AVS_WRITEDATA[15:0];
          iacs_pkg::ADDR_SELECT:  dev_select <= AVS_WRITEDATA[1:0];
          default: ;
        endcase
      end
      // set wins over the clear from a new go
      if (done_set) done_flag <= 1'b1;
      else if (go_pulse) done_flag <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer

  typedef enum logic [7:0] {
    ST_IDLE   = 8'b0000_0001,
    ST_WAIT   = 8'b0000_0010,
    ST_START  = 8'b0000_0100,
    ST_BYTE   = 8'b0000_1000,
    ST_ACK    = 8'b0001_0000,
    ST_RBYTE  = 8'b0010_0000,
    ST_MACK   = 8'b0100_0000,
    ST_STOP   = 8'b1000_0000
  } iacs_state_type;

  iacs_state_type state;
  iacs_pkg::iacs_req_type req;
  iacs_pkg::iacs_rsp_type rsp;
  logic [7:0] shift;
  logic [2:0] bit_idx;
  logic [1:0] byte_no;      // 0 write addr, 1 command, 2 read addr
  logic [7:0] left;
  logic [15:0] idle_cnt;
  logic       issued;
  logic       bus_scl_oe;
  logic       bus_sda_oe;

  wire bus_idle = scl_s && sda_s;   // R5
  wire last_rd  = (left == 8'h01);  // R8 R9

  iacs_bit_engine u_bits (
    .clk_sys (CLK_SYS),
    .srst    (SRST),
    .quarter (quarter),
    .req     (req),
    .rsp     (rsp),
    .scl_in  (scl_s),
    .sda_in  (sda_s),
    .scl_oe  (bus_scl_oe),
    .sda_oe  (bus_sda_oe)
  );

  assign done_set = (state == ST_STOP) && rsp.done;

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      state     <= ST_IDLE;
      req       <= '{op: iacs_pkg::OP_IDLE, wbit: 1'b1};
      shift     <= 8'h00;
      bit_idx   <= 3'd0;
      byte_no   <= 2'd0;
      left      <= 8'h00;
      idle_cnt  <= 16'h0000;
      issued    <= 1'b0;
      busy      <= 1'b0;
      nack_seen <= 1'b0;
      result    <= 8'h00;
    end else begin
      req.op <= iacs_pkg::OP_IDLE;
      case (state)
        ST_IDLE: if (go_pulse) begin
          busy      <= 1'b1;
          nack_seen <= 1'b0;
          byte_no   <= 2'd0;
          left      <= (read_count == 8'h00) ? 8'h01 : read_count;
          idle_cnt  <= 16'h0000;
          state     <= ST_WAIT;
        end
        ST_WAIT: begin
          idle_cnt <= bus_idle ? idle_cnt + 16'h0001 : 16'h0000;
          if (idle_cnt == 16'(SETTLE_CYCLES)) begin   // R5
            req.op <= iacs_pkg::OP_START;             // R1 R2
            issued <= 1'b1;
            state  <= ST_START;
          end
        end
        ST_START: if (rsp.done) begin
          shift   <= (byte_no == 2'd0) ? addr_byte(dev_select, iacs_pkg::DIR_WRITE) :
                                         addr_byte(dev_select, iacs_pkg::DIR_READ);  // R10 R13
          bit_idx <= 3'd7;
          issued  <= 1'b0;
          state   <= ST_BYTE;
        end
        ST_BYTE: begin
          if (!issued) begin
            req    <= '{op: iacs_pkg::OP_WBIT, wbit: shift[7]};  // R4 R6
            issued <= 1'b1;
          end else if (rsp.done) begin
            shift  <= {shift[6:0], 1'b0};
            issued <= 1'b0;
            if (bit_idx == 3'd0) state <= ST_ACK;
            else bit_idx <= bit_idx - 3'd1;
          end
        end
        ST_ACK: begin
          if (!issued) begin
            req    <= '{op: iacs_pkg::OP_RBIT, wbit: 1'b1};  // R7
            issued <= 1'b1;
          end else if (rsp.done) begin
            issued <= 1'b0;
            if (rsp.rbit) begin                 // R14 R15: no ack
              nack_seen <= 1'b1;
              req.op    <= iacs_pkg::OP_STOP;
              issued    <= 1'b1;
              state     <= ST_STOP;
            end else if (byte_no == 2'd0) begin
              shift   <= cmd_byte;              // R17 R21
              bit_idx <= 3'd7;
              byte_no <= 2'd1;
              state   <= ST_BYTE;
            end else if (byte_no == 2'd1) begin
              byte_no <= 2'd2;                  // R10 R24: restart to read
              req.op  <= iacs_pkg::OP_RSTART;
              issued  <= 1'b1;
              state   <= ST_START;
            end else begin
              bit_idx <= 3'd7;                  // R16 R23
              state   <= ST_RBYTE;
            end
          end
        end
        ST_RBYTE: begin
          if (!issued) begin
            req    <= '{op: iacs_pkg::OP_RBIT, wbit: 1'b1};
            issued <= 1'b1;
          end else if (rsp.done) begin
            shift  <= {shift[6:0], rsp.rbit};   // R22: msb first
            issued <= 1'b0;
            if (bit_idx == 3'd0) state <= ST_MACK;
            else bit_idx <= bit_idx - 3'd1;
          end
        end
        ST_MACK: begin
          if (!issued) begin
            result <= shift;
            req    <= '{op: iacs_pkg::OP_WBIT, wbit: last_rd};  // R8
            issued <= 1'b1;
          end else if (rsp.done) begin
            issued <= 1'b0;
            left   <= left - 8'h01;
            if (last_rd) begin
              req.op <= iacs_pkg::OP_STOP;      // R3 R8
              issued <= 1'b1;
              state  <= ST_STOP;
            end else begin
              bit_idx <= 3'd7;                  // R9
              state   <= ST_RBYTE;
            end
          end
        end
        ST_STOP: if (rsp.done) begin
          busy   <= 1'b0;
          issued <= 1'b0;
          state  <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // open-drain outputs, registered
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      SCL_OUT <= 1'b0;
      SDA_OUT <= 1'b0;
      SCL_OE  <= 1'b0;
      SDA_OE  <= 1'b0;
    end else begin
      SCL_OUT <= 1'b0;
      SDA_OUT <= 1'b0;
      SCL_OE  <= bus_scl_oe;
      SDA_OE  <= bus_sda_oe;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  property p_start_shape;
    @(posedge CLK_SYS) disable iff (SRST)
    (SCL_OE == 1'b0) && $rose(SDA_OE) |-> !$past(SCL_OE);
  endproperty
  a_start_shape: assert property (p_start_shape) else $error("data fell with clock not high"); // R2

  property p_stop_shape;
    @(posedge CLK_SYS) disable iff (SRST)
    $fell(SDA_OE) && !SCL_OE |-> (state == ST_STOP);
  endproperty
  a_stop_shape: assert property (p_stop_shape) else $error("data rose high in wrong state"); // R3

  property p_data_stable;
    @(posedge CLK_SYS) disable iff (SRST)
    !SCL_OE && !$past(SCL_OE) && (state inside {ST_BYTE, ST_RBYTE, ST_MACK}) |-> $stable(SDA_OE);
  endproperty
  a_data_stable: assert property (p_data_stable) else $error("data moved while clock high"); // R4

  property p_idle_start;
    @(posedge CLK_SYS) disable iff (SRST)
    (state == ST_WAIT) ##1 (state == ST_START) |-> $past(bus_idle, 2);
  endproperty
  a_idle_start: assert property (p_idle_start) else $error("start issued on busy bus"); // R5

  property p_ack_released;
    @(posedge CLK_SYS) disable iff (SRST)
    (state == ST_ACK) && !SCL_OE |-> !SDA_OE;
  endproperty
  a_ack_released: assert property (p_ack_released) else $error("host drove ack slot"); // R7

  property p_last_nack;
    @(posedge CLK_SYS) disable iff (SRST)
    (state == ST_MACK) && !SCL_OE |-> (SDA_OE == (left != 8'h01));
  endproperty
  a_last_nack: assert property (p_last_nack) else $error("wrong ack on read byte"); // R8

  property p_nack_stops;
    @(posedge CLK_SYS) disable iff (SRST)
    (state == ST_ACK) && rsp.done && rsp.rbit |=> (state == ST_STOP) && nack_seen;
  endproperty
  a_nack_stops: assert property (p_nack_stops) else $error("address nack did not stop"); // R14

  property p_addr_dir;
    @(posedge CLK_SYS) disable iff (SRST)
    (state == ST_START) && rsp.done |=> shift[0] == (byte_no == 2'd2) && shift[7:3] == iacs_pkg::ADDR_PREFIX;
  endproperty
  a_addr_dir: assert property (p_addr_dir) else $error("address byte malformed"); // R11 R13

  property p_done_after_stop;
    @(posedge CLK_SYS) disable iff (SRST)
    done_set |=> ##[0:2] (done_flag && !busy);
  endproperty
  a_done_after_stop: assert property (p_done_after_stop) else $error("stop did not finish"); // R3

  property p_wait_bus;
    @(posedge CLK_SYS) disable iff (SRST)
    (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST;
  endproperty
  a_wait_bus: assert property (p_wait_bus) else $error("waitrequest held too long");

  c_read_byte: cover property (@(posedge CLK_SYS) disable iff (SRST) (state == ST_MACK) && rsp.done && last_rd);
  c_multi:     cover property (@(posedge CLK_SYS) disable iff (SRST) (state == ST_MACK) && rsp.done && !last_rd);
  c_nack:      cover property (@(posedge CLK_SYS) disable iff (SRST) (state == ST_ACK) && rsp.done && rsp.rbit);

endmodule // iacs_host
